// *** rtl/aio_axis_io.sv ***
// Per-axis auxiliary I/O: general outputs, input readback, position latch, drive select.
// Assumes an APB master on i_sys_clk, same-clock dedicated function sources, async pins.
`timescale 1ns/1ps
`default_nettype none
module aio_axis_io #(
    parameter int POS_W = 32
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_srst,
    input  wire logic             i_clk_en,
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [7:0]       i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic                  o_pready,
    output logic      [31:0]      o_prdata,
    output logic                  o_pslverr,
    input  wire logic [3:0]       i_input_pins,
    input  wire logic             i_latch_pin,
    input  wire logic [POS_W-1:0] i_position,
    input  wire logic [3:0]       i_dedicated_pins,
    input  wire logic             i_cmp_pulse,
    output logic      [3:0]       o_shared_output_pins,
    output logic                  o_cmp_pulse,
    output logic                  o_func_disable,
    output logic                  o_jog_drive,
    output logic                  o_handwheel_pulse_drive,
    output logic                  o_drive_stop
);
    function automatic logic in_range(input logic [3:0] idx, input logic [3:0] lo,
                                      input logic [3:0] hi);
        in_range = (idx >= lo) && (idx <= hi);
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // Registers
    logic             pready_q;
    logic [31:0]      prdata_q;
    logic             pslverr_q;
    logic             gen_en_q;
    logic [1:0]       drive_sel_q;
    logic [3:0]       dout_q;
    logic [3:0]       dout_sel_q;
    logic [3:0]       din_sel_q;
    logic             flag_q;
    logic [POS_W-1:0] latch_data_q;
    logic             latch_prev_q;
    logic [3:0]       pins_q;
    logic             cmp_pulse_q;
    logic             func_dis_q;
    logic             jog_q;
    logic             hw_q;
    logic             stop_q;

    // Synchronised pins
    logic [4:0] pins_sync;

    aio_sync #(.W(5)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_async   ({i_latch_pin, i_input_pins}),
        .o_sync    (pins_sync)
    );

    wire [3:0] din_s     = pins_sync[3:0];
    wire       latch_s   = pins_sync[4];

    localparam int CHAN_LSB = aio_pkg::CHAN_LSB;
    localparam int CHAN_W   = aio_pkg::CHAN_W;

    // Bus decode; a two-cycle access gives time to register read data
    wire       acc_first = i_psel & i_penable & ~pready_q;
    wire       acc_done  = i_psel & i_penable & pready_q;
    wire       wr_en     = acc_done & i_pwrite;
    wire [3:0] wchan     = i_pwdata[CHAN_LSB +: CHAN_W];
    wire       wbit      = i_pwdata[aio_pkg::DOUT_DATA_BIT];

    wire h_ctrl  = hit(i_paddr, aio_pkg::OFF_CTRL);
    wire h_dset  = hit(i_paddr, aio_pkg::OFF_DOUT_SET);
    wire h_dget  = hit(i_paddr, aio_pkg::OFF_DOUT_GET);
    wire h_iget  = hit(i_paddr, aio_pkg::OFF_DIN_GET);
    wire h_lstat = hit(i_paddr, aio_pkg::OFF_LATCH_STAT);
    wire h_ldata = hit(i_paddr, aio_pkg::OFF_LATCH_DATA);
    wire h_lcmd  = hit(i_paddr, aio_pkg::OFF_LATCH_CMD);
    wire mapped  = h_ctrl | h_dset | h_dget | h_iget | h_lstat | h_ldata | h_lcmd;

    wire dout_ok = in_range(wchan, aio_pkg::DOUT_CHAN_LO, aio_pkg::DOUT_CHAN_HI);
    wire din_ok  = in_range(wchan, aio_pkg::DIN_CHAN_LO, aio_pkg::DIN_CHAN_HI);

    // A channel write out of range is refused with an error and changes nothing
    wire bad_chan = i_pwrite & (((h_dset | h_dget) & ~dout_ok) | (h_iget & ~din_ok));
    wire err_d    = ~mapped | bad_chan;

    wire wr_ctrl = wr_en & h_ctrl;
    wire wr_dset = wr_en & h_dset & dout_ok;
    wire wr_dget = wr_en & h_dget & dout_ok;
    wire wr_iget = wr_en & h_iget & din_ok;
    wire wr_lcmd = wr_en & h_lcmd;

    wire [1:0] dout_idx = 2'(dout_sel_q - aio_pkg::DOUT_CHAN_LO);
    wire       dout_bit = dout_q[dout_idx];
    wire       din_bit  = din_s[din_sel_q[1:0]];

    wire [31:0] rd_ctrl = {29'h0, drive_sel_q, gen_en_q};
    wire [31:0] rd_data = h_ctrl  ? rd_ctrl :
                          h_dset  ? {28'h0, dout_q} :
                          h_dget  ? {31'h0, dout_bit} :
                          h_iget  ? {31'h0, din_bit} :
                          h_lstat ? {31'h0, flag_q} :
                          h_ldata ? 32'(latch_data_q) :
                          aio_pkg::RST_WORD;

    // Latch events: pin rising edge or software trigger
    wire latch_evt = (latch_s & ~latch_prev_q) | (wr_lcmd & i_pwdata[aio_pkg::CMD_TRIG_BIT]);
    wire latch_clr = wr_lcmd & i_pwdata[aio_pkg::CMD_RESET_BIT];

    wire [1:0] drv_wr  = i_pwdata[aio_pkg::CTRL_DRV_LSB +: aio_pkg::DRV_W];
    wire       gen_wr  = i_pwdata[aio_pkg::CTRL_GEN_EN_BIT];
    wire [1:0] drv_now = wr_ctrl ? drv_wr : drive_sel_q;

    // Software owns the pins only while the general enable is set
    wire [3:0] pins_d  = gen_en_q ? dout_q : i_dedicated_pins;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pready_q  <= 1'b0;
            prdata_q  <= aio_pkg::RST_WORD;
            pslverr_q <= 1'b0;
        end else if (i_clk_en) begin
            pready_q  <= acc_first;
            pslverr_q <= acc_first & err_d;
            if (acc_first && !i_pwrite) begin
                prdata_q <= rd_data;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            gen_en_q    <= 1'b0;
            drive_sel_q <= aio_pkg::RST_DRV;
            dout_q      <= aio_pkg::RST_NIBBLE;
            dout_sel_q  <= aio_pkg::DOUT_CHAN_LO;
            din_sel_q   <= aio_pkg::DIN_CHAN_LO;
        end else if (i_clk_en) begin
            if (wr_ctrl) begin
                gen_en_q    <= gen_wr;
                drive_sel_q <= drv_wr;
            end
            if (wr_dset) begin
                dout_q[2'(wchan - aio_pkg::DOUT_CHAN_LO)] <= wbit;
            end
            if (wr_dget) begin
                dout_sel_q <= wchan;
            end
            if (wr_iget) begin
                din_sel_q <= wchan;
            end
        end
    end

    // The set wins over a reset command landing in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            flag_q       <= 1'b0;
            latch_data_q <= '0;
            latch_prev_q <= 1'b0;
        end else if (i_clk_en) begin
            latch_prev_q <= latch_s;
            if (latch_evt) begin
                flag_q       <= 1'b1;
                latch_data_q <= i_position;
            end else if (latch_clr) begin
                flag_q       <= 1'b0;
                latch_data_q <= '0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pins_q      <= aio_pkg::RST_NIBBLE;
            cmp_pulse_q <= 1'b0;
            func_dis_q  <= 1'b0;
            jog_q       <= 1'b0;
            hw_q        <= 1'b0;
            stop_q      <= 1'b0;
        end else if (i_clk_en) begin
            pins_q      <= pins_d;
            cmp_pulse_q <= i_cmp_pulse & ~gen_en_q;
            func_dis_q  <= gen_en_q;
            jog_q       <= (drv_now == aio_pkg::DRV_JOG);
            hw_q        <= (drv_now == aio_pkg::DRV_HANDWHEEL);
            // Step jog code is held but drives nothing: it is reserved
            stop_q      <= wr_ctrl & (drv_wr == aio_pkg::DRV_OFF);
        end
    end

    assign o_pready                = pready_q;
    assign o_prdata                = prdata_q;
    assign o_pslverr               = pslverr_q;
    assign o_shared_output_pins    = pins_q;
    assign o_cmp_pulse             = cmp_pulse_q;
    assign o_func_disable          = func_dis_q;
    assign o_jog_drive             = jog_q;
    assign o_handwheel_pulse_drive = hw_q;
    assign o_drive_stop            = stop_q;

    // Checks
    flag_set_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && latch_evt |=> flag_q && latch_data_q == $past(i_position))
        else $error("latch event did not set captured flag");

    flag_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && latch_clr && !latch_evt |=> !flag_q && latch_data_q == '0)
        else $error("latch reset did not clear flag and data");

    dout_write_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && wr_en && h_dset && dout_ok
        |=> dout_q[2'($past(wchan) - aio_pkg::DOUT_CHAN_LO)] == $past(wbit))
        else $error("output write not stored");

    dout_refuse_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && wr_en && h_dset && !dout_ok |=> $stable(dout_q) && !o_pready)
        else $error("out of range output write changed state");

    pins_owned_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && gen_en_q |=> o_shared_output_pins == $past(dout_q))
        else $error("general outputs not on shared pins");

    cmp_block_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && gen_en_q |=> !o_cmp_pulse)
        else $error("compare pulse while general enable set");

    dout_read_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && acc_first && !i_pwrite && h_dget
        |=> o_pready && o_prdata == {31'h0, $past(dout_bit)})
        else $error("output readback wrong");

    din_read_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && acc_first && !i_pwrite && h_iget
        |=> o_prdata == {31'h0, $past(din_s[din_sel_q[1:0]])})
        else $error("input readback wrong");

    drive_sel_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && wr_ctrl |=> o_jog_drive == ($past(drv_wr) == aio_pkg::DRV_JOG)
        && o_handwheel_pulse_drive == ($past(drv_wr) == aio_pkg::DRV_HANDWHEEL)
        && o_drive_stop == ($past(drv_wr) == aio_pkg::DRV_OFF))
        else $error("drive select outputs wrong");

    pins_return_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && !gen_en_q |=> o_shared_output_pins == $past(i_dedicated_pins))
        else $error("shared pins not returned to dedicated functions");

    flag_both_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && latch_evt && latch_clr |=> flag_q)
        else $error("capture lost to reset in same cycle");

    data_clr_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !flag_q |-> latch_data_q == '0)
        else $error("captured data left while flag clear");

    dout_err_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && acc_first && i_pwrite && h_dset && !dout_ok |=> o_pready && o_pslverr)
        else $error("out of range output write not flagged");

    func_dis_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && gen_en_q |=> o_func_disable)
        else $error("dedicated functions not disabled");

    sel_range_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        in_range(dout_sel_q, aio_pkg::DOUT_CHAN_LO, aio_pkg::DOUT_CHAN_HI)
        && in_range(din_sel_q, aio_pkg::DIN_CHAN_LO, aio_pkg::DIN_CHAN_HI))
        else $error("channel select left its range");

    din_refuse_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && wr_en && h_iget && !din_ok |=> $stable(din_sel_q))
        else $error("out of range input select taken");

    stop_only_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && !wr_ctrl |=> !o_drive_stop)
        else $error("stop pulse without control write");

    cmp_pass_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && !gen_en_q |=> o_cmp_pulse == $past(i_cmp_pulse))
        else $error("compare pulse not passed through");

    cmp_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && !i_cmp_pulse |=> !o_cmp_pulse)
        else $error("compare pulse without source");
endmodule
`default_nettype wire

// *** rtl/aio_pkg.sv ***
// Constants for the per-axis auxiliary I/O, latch status and drive select block.
// Assumes byte addresses on a 32-bit APB bus, one aligned word per register.
package aio_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_DOUT_SET   = 8'h04;
    localparam logic [7:0] OFF_DOUT_GET   = 8'h08;
    localparam logic [7:0] OFF_DIN_GET    = 8'h0c;
    localparam logic [7:0] OFF_LATCH_STAT = 8'h10;
    localparam logic [7:0] OFF_LATCH_DATA = 8'h14;
    localparam logic [7:0] OFF_LATCH_CMD  = 8'h18;

    // Control register fields
    localparam int CTRL_GEN_EN_BIT = 0;
    localparam int CTRL_DRV_LSB    = 1;
    localparam int DRV_W           = 2;

    // Channel select fields
    localparam int CHAN_LSB      = 0;
    localparam int CHAN_W        = 4;
    localparam int DOUT_DATA_BIT = 8;
    localparam logic [3:0] DOUT_CHAN_LO = 4'h4;
    localparam logic [3:0] DOUT_CHAN_HI = 4'h7;
    localparam logic [3:0] DIN_CHAN_LO  = 4'h0;
    localparam logic [3:0] DIN_CHAN_HI  = 4'h3;

    // Latch command bits
    localparam int CMD_RESET_BIT = 0;
    localparam int CMD_TRIG_BIT  = 1;

    // External drive select codes
    localparam logic [1:0] DRV_OFF       = 2'h0;
    localparam logic [1:0] DRV_JOG       = 2'h1;
    localparam logic [1:0] DRV_HANDWHEEL = 2'h2;
    localparam logic [1:0] DRV_JOG_STEP  = 2'h3;

    // Reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [3:0]  RST_NIBBLE = 4'h0;
    localparam logic [1:0]  RST_DRV   = 2'h0;
endpackage

// *** rtl/aio_sync.sv ***
// Two-flop synchroniser for a group of independent pin levels.
// Assumes the bits are unrelated; no word coherence is given.
`timescale 1ns/1ps
`default_nettype none
module aio_sync #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_srst,
    input  wire logic         i_clk_en,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (i_clk_en) begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

// *** testbench/aio_field_model.sv ***
// Field wiring model: input switches, latch sensor and position encoder.
// Assumes the bench hands it levels; it moves its pins just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module aio_field_model (
    input  wire logic        i_sys_clk,
    input  wire logic [3:0]  i_switch_lvl,
    input  wire logic        i_latch_req,
    input  wire logic [31:0] i_pos_val,
    output logic      [3:0]  o_input_pins,
    output logic             o_latch_pin,
    output logic      [31:0] o_position
);
    // Edge-aligned changes are the worst case for the synchronisers
    initial begin
        o_input_pins = 4'h0;
        o_latch_pin  = 1'b0;
        o_position   = 32'h0000_0000;
        forever begin
            @(posedge i_sys_clk);
            o_input_pins <= i_switch_lvl;
            o_latch_pin  <= i_latch_req;
            o_position   <= i_pos_val;
        end
    end
endmodule
`default_nettype wire

// *** testbench/axis_aux_io_latch_status_tb.sv ***
// Self-checking bench for the per-axis auxiliary I/O block.
// Assumes an APB slave with one wait state and a field model on the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
    compares++; \
    if ((gt) !== (ex)) begin \
        error_cnt++; \
        $display("MISMATCH %s exp %h got %h", nm, ex, gt); \
    end \
end
module axis_aux_io_latch_status_tb;
    logic        sys_clk = 1'b0;
    logic        srst, psel, penable, pwrite, pready, pslverr, latch_pin, latch_req;
    logic        cmp_in, cmp_out, fdis, jog_drive, hw, stop, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, position, pos_val, rd, rnd;
    logic [3:0]  in_pins, sw_lvl, ded, sh_pins, dout;
    logic        clk_en;
    int          error_cnt, compares, stop_cnt, cyc, i, n;
    int          n_bad[2] = '{3, 8};

    aio_axis_io u_dut (.i_sys_clk(sys_clk), .i_srst(srst), .i_clk_en(clk_en),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_input_pins(in_pins), .i_latch_pin(latch_pin), .i_position(position),
        .i_dedicated_pins(ded), .i_cmp_pulse(cmp_in), .o_shared_output_pins(sh_pins),
        .o_cmp_pulse(cmp_out), .o_func_disable(fdis), .o_jog_drive(jog_drive),
        .o_handwheel_pulse_drive(hw), .o_drive_stop(stop));
    aio_field_model u_field (.i_sys_clk(sys_clk), .i_switch_lvl(sw_lvl),
        .i_latch_req(latch_req), .i_pos_val(pos_val), .o_input_pins(in_pins),
        .o_latch_pin(latch_pin), .o_position(position));

    always #4 sys_clk = ~sys_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] exp_ctrl(input logic [1:0] drv, input logic en);
        return (32'(drv) << aio_pkg::CTRL_DRV_LSB) | (32'(en) << aio_pkg::CTRL_GEN_EN_BIT);
    endfunction

    task complete_run;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task wait_n(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    // Holds the request until pready is seen; one idle cycle keeps drivers single-assigned
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Software writes one general output bit and keeps its own image
    task dout_wr(input int ch, input logic v);
        apb(1'b1, aio_pkg::OFF_DOUT_SET, (32'(v) << aio_pkg::DOUT_DATA_BIT) | 32'(ch));
        dout[ch-4] = v;
    endtask

    always @(posedge sys_clk) begin
        if (stop === 1'b1) stop_cnt++;
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run;
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, latch_req, cmp_in} = '0;
        {sw_lvl, ded, pos_val, dout} = '0;
        clk_en = 1'b1;
        srst = 1'b1;
        rnd  = 32'h8c5c6ef4;
        wait_n(16);
        srst <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, aio_pkg::OFF_LATCH_STAT, 32'h0);
        `CHK("flag_rst", 32'h0, rd)
        for (i = 0; i < 4; i++) begin
            n = stop_cnt;
            apb(1'b1, aio_pkg::OFF_CTRL, exp_ctrl(2'(i), 1'b0));
            wait_n(2);
            `CHK("jog", (i == 1), jog_drive)
            `CHK("hwheel", (i == 2), hw)
            `CHK("stop_cnt", (i == 0) ? n + 1 : n, stop_cnt)
            apb(1'b0, aio_pkg::OFF_CTRL, 32'h0);
            `CHK("ctrl_rd", exp_ctrl(2'(i), 1'b0), rd)
        end
        rnd = lfsr(rnd);
        ded <= rnd[3:0];
        for (i = 4; i < 8; i++) dout_wr(i, rnd[i]);
        wait_n(2);
        `CHK("pins_ded", ded, sh_pins)
        `CHK("fdis_off", 1'b0, fdis)
        cmp_in <= 1'b1;
        @(posedge sys_clk);
        cmp_in <= 1'b0;
        @(posedge sys_clk);
        `CHK("cmp_pass", 1'b1, cmp_out)
        // Enable now: general writes made before it are held and reach the pins once it is set
        apb(1'b1, aio_pkg::OFF_CTRL, exp_ctrl(aio_pkg::DRV_OFF, 1'b1));
        wait_n(2);
        `CHK("pins_gen", dout, sh_pins)
        `CHK("fdis_on", 1'b1, fdis)
        for (i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            cmp_in <= rnd[0];
            @(posedge sys_clk);
            `CHK("cmp_gate", 1'b0, cmp_out)
        end
        cmp_in <= 1'b0;
        for (i = 4; i < 8; i++) begin
            rnd = lfsr(rnd);
            dout_wr(i, rnd[0]);
            apb(1'b1, aio_pkg::OFF_DOUT_GET, 32'(i));
            apb(1'b0, aio_pkg::OFF_DOUT_GET, 32'h0);
            `CHK("dout_rd", 32'(rnd[0]), rd)
        end
        wait_n(1);
        `CHK("pins_new", dout, sh_pins)
        apb(1'b0, aio_pkg::OFF_DOUT_SET, 32'h0);
        `CHK("dout_img", {28'h0, dout}, rd)
        foreach (n_bad[j]) begin
            apb(1'b1, aio_pkg::OFF_DOUT_SET,
                (32'h1 << aio_pkg::DOUT_DATA_BIT) | 32'(n_bad[j]));
            `CHK("bad_ch_err", 1'b1, er)
        end
        wait_n(2);
        `CHK("pins_kept", dout, sh_pins)
        apb(1'b1, aio_pkg::OFF_CTRL, 32'h0);
        wait_n(2);
        `CHK("pins_back", ded, sh_pins)
        // A frozen block must ignore the pin change until the enable returns
        clk_en <= 1'b0;
        ded    <= ~ded;
        wait_n(3);
        `CHK("pins_frozen", ~ded, sh_pins)
        clk_en <= 1'b1;
        wait_n(2);
        `CHK("pins_thaw", ded, sh_pins)
        rnd = lfsr(rnd);
        sw_lvl <= rnd[3:0];
        wait_n(5);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, aio_pkg::OFF_DIN_GET, 32'(i));
            apb(1'b0, aio_pkg::OFF_DIN_GET, 32'h0);
            `CHK("din_rd", 32'(sw_lvl[i]), rd)
        end
        apb(1'b1, aio_pkg::OFF_DIN_GET, 32'h4);
        `CHK("din_bad", 1'b1, er)
        rnd = lfsr(rnd);
        pos_val <= rnd;
        latch_req <= 1'b1;
        wait_n(8);
        latch_req <= 1'b0;
        apb(1'b0, aio_pkg::OFF_LATCH_STAT, 32'h0);
        `CHK("flag_set", 32'h1, rd)
        apb(1'b0, aio_pkg::OFF_LATCH_DATA, 32'h0);
        `CHK("latch_data", pos_val, rd)
        apb(1'b1, aio_pkg::OFF_LATCH_CMD, 32'h1);
        apb(1'b0, aio_pkg::OFF_LATCH_STAT, 32'h0);
        `CHK("flag_clr", 32'h0, rd)
        apb(1'b0, aio_pkg::OFF_LATCH_DATA, 32'h0);
        `CHK("data_clr", 32'h0, rd)
        apb(1'b1, aio_pkg::OFF_LATCH_CMD, 32'h2);
        apb(1'b0, aio_pkg::OFF_LATCH_STAT, 32'h0);
        `CHK("flag_sw", 32'h1, rd)
        apb(1'b1, aio_pkg::OFF_LATCH_CMD, 32'h1);
        apb(1'b1, aio_pkg::OFF_LATCH_CMD, 32'h3);
        apb(1'b0, aio_pkg::OFF_LATCH_STAT, 32'h0);
        `CHK("flag_win", 32'h1, rd)
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("unmapped", {1'b1, 32'h0}, {er, rd})
        complete_run;
    end
endmodule
`default_nettype wire
